// File: rtl/i2m_brg.sv
// reloadable down counter that paces every scl phase
// assumes load is held while the clock must stay suspended
`timescale 1ns/1ps
module i2m_brg #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] reload,
    output logic              done
);

    logic [W-1:0] cnt_q;

    // rollover when the count reaches zero and is not held
    assign done = ~load & (cnt_q == '0);

    // reload on hold or rollover, count down otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load | done) begin
            cnt_q <= reload;
        end else begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule

// File: rtl/i2m_engine.sv
// two-wire bus master engine with apb registers and one interrupt
// assumes open-drain pads outside: oe high pulls the line low
//
// Function
// - master runs only with master mode encoding and port enable set
// - port pulls sda or scl low only when needed, else releases them
// - start-seen and stop-seen clear on reset and when port disabled
// - firmware mode keeps only start/stop detection; software drives pins
// - event flag sets on start, stop, byte, acknowledge, repeated start
// - no queuing; buffer write during activity is dropped, sets collision
// - own start/stop detection suspended while generating start or stop
// - finished start or stop clears its request and sets the event
// - master makes all clocks, start, stop; repeated start keeps the bus
// - transmit first byte is address plus direction bit zero
// - eight bits per byte sent, slave acknowledges each byte
// - receive first byte is address plus direction bit one
// - eight bits received per byte, master returns an acknowledge
// - scl frequency comes from the baud rate counter
// - counter halts while released scl is not yet sampled high
// - scl seen high reloads counter from rate low byte, counting resumes
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "i2m_map.svh"
module i2m_engine (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             irq
);
    import i2m_pkg::*;

    logic [1:0]          pin_s;
    logic [3:0]          mode_q;
    logic                en_q;
    logic                write_collision_flag_q;
    logic [7:0]          rate_q;
    logic [`I2M_NEV-1:0] mask_q;
    logic [`I2M_NEV-1:0] irqs_q;
    logic [`I2M_NEV-1:0] irqs_d;
    logic [`I2M_NEV-1:0] ev;
    logic                start_req_q;
    logic                rstart_req_q;
    logic                stop_req_q;
    logic                rcv_q;
    logic                ackseq_q;
    logic                ackdt_q;
    logic                fw_sda_q;
    logic                fw_scl_q;
    logic [7:0]          sh_q;
    logic                ackst_q;
    i2m_state_e          st_q;
    i2m_state_e          st_d;
    logic [1:0]          step_q;
    logic [1:0]          step_d;
    logic [3:0]          bit_q;
    logic [3:0]          bit_d;
    i2m_kind_e           kind_q;
    i2m_kind_e           kind_d;
    logic                sda_d;
    logic                scl_d;
    logic                nh;
    logic                smp;
    logic                gen_s;
    logic                gen_p;
    logic                gen_rs;
    logic                sseen_q;
    logic                pseen_q;
    logic                sda_prev_q;
    logic                sda_oe_q;
    logic                scl_oe_q;
    logic                lo_q;
    logic                irq_q;
    logic [31:0]         prdata_q;
    logic [31:0]         rd_data;
    logic                pready_q;
    logic                pslverr_q;
    logic                brg_done;

    // pins pass two flip-flops before any use
    i2m_sync #(
        .W (2)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({scl_in, sda_in}),
        .q     (pin_s)
    );
    wire scl_s = pin_s[1];
    wire sda_s = pin_s[0];

    wire master_en = en_q & (mode_q == `I2M_MODE_MST);
    wire fw_en     = en_q & (mode_q == `I2M_MODE_FW);

    // activity: a running sequence or a pending request
    wire pend = start_req_q | rstart_req_q | stop_req_q | rcv_q | ackseq_q;
    wire busy = (st_q != S_IDLE) | pend;

    // apb decode
    wire setup    = psel & ~penable;
    wire acc      = psel & penable & pready_q;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire hit_ctrl = paddr == `I2M_CTRL_OFF;
    wire hit_cmd  = paddr == `I2M_CMD_OFF;
    wire hit_stat = paddr == `I2M_STAT_OFF;
    wire hit_buf  = paddr == `I2M_BUF_OFF;
    wire hit_rate = paddr == `I2M_RATE_OFF;
    wire hit_ist  = paddr == `I2M_IST_OFF;
    wire hit_imsk = paddr == `I2M_IMSK_OFF;
    wire mapped   = hit_ctrl | hit_cmd | hit_stat | hit_buf | hit_rate
                  | hit_ist | hit_imsk;
    wire wr_ctrl  = wr & hit_ctrl;
    wire wr_cmd   = wr & hit_cmd;
    wire buf_wr   = wr & hit_buf & master_en;
    // a buffer write only starts a byte when nothing is active
    wire tx_go    = buf_wr & ~busy;
    wire write_collision_flag_set = buf_wr & busy;
    wire cmd_ok   = wr_cmd & master_en & ~busy;
    wire launch   = (st_q == S_IDLE) & (st_d == S_BIT);

    // counter suspended while released scl still reads low
    wire brg_load = (st_q == S_IDLE) | (nh & ~scl_s);

    // reload from rate low byte on release of the hold
    i2m_brg #(
        .W (8)
    ) u_brg (
        .clk    (pclk),
        .rst_n  (presetn),
        .load   (brg_load),
        .reload (rate_q),
        .done   (brg_done)
    );

    // detection sleeps during own start and stop
    wire det_on    = (master_en | fw_en) & (st_q != S_START)
                   & (st_q != S_STOP);
    wire start_det = det_on & scl_s & sda_prev_q & ~sda_s;
    wire stop_det  = det_on & scl_s & ~sda_prev_q & sda_s;

    // value driven in the current bit slot, one means released
    wire bit_val = (kind_q == K_TX && bit_q < `I2M_TX_LAST) ? sh_q[7] :
                   (kind_q == K_ACK) ? ackdt_q : 1'b1;
    wire [3:0] last = (kind_q == K_TX) ? `I2M_TX_LAST :
                      (kind_q == K_RX) ? `I2M_RX_LAST : 4'h0;

    // sequencer: next state, pin targets and completion pulses
    always_comb begin
        st_d   = st_q;
        step_d = step_q;
        bit_d  = bit_q;
        kind_d = kind_q;
        sda_d  = sda_oe_q;
        scl_d  = scl_oe_q;
        nh     = 1'b0;
        smp    = 1'b0;
        gen_s  = 1'b0;
        gen_p  = 1'b0;
        gen_rs = 1'b0;
        case (st_q)
            S_IDLE: begin
                step_d = 2'd0;
                bit_d  = 4'h0;
                if (start_req_q) begin
                    st_d = S_START;
                end else if (rstart_req_q) begin
                    st_d = S_RSTART;
                end else if (stop_req_q) begin
                    st_d = S_STOP;
                end else if (rcv_q) begin
                    st_d   = S_BIT;
                    kind_d = K_RX;
                end else if (ackseq_q) begin
                    st_d   = S_BIT;
                    kind_d = K_ACK;
                end else if (tx_go) begin
                    st_d   = S_BIT;
                    kind_d = K_TX;
                end
            end
            // start is sda low under high scl, then scl low
            S_START: begin
                sda_d = 1'b1;
                scl_d = step_q[0];
                if (brg_done) begin
                    if (step_q == 2'd0) begin
                        step_d = 2'd1;
                    end else begin
                        st_d  = S_IDLE;
                        gen_s = 1'b1;
                    end
                end
            end
            // repeated start keeps ownership, no stop in between
            S_RSTART: begin
                scl_d = (step_q == 2'd0) | (step_q == 2'd3);
                sda_d = step_q[1];
                nh    = step_q == 2'd1;
                if (brg_done) begin
                    step_d = step_q + 2'd1;
                    if (step_q == 2'd3) begin
                        st_d   = S_IDLE;
                        gen_rs = 1'b1;
                    end
                end
            end
            // stop is sda low, scl released, then sda released
            S_STOP: begin
                scl_d = step_q == 2'd0;
                sda_d = step_q != 2'd2;
                nh    = step_q == 2'd1;
                if (brg_done) begin
                    step_d = step_q + 2'd1;
                    if (step_q == 2'd2) begin
                        st_d  = S_IDLE;
                        gen_p = 1'b1;
                    end
                end
            end
            // one low phase and one high phase per bit
            S_BIT: begin
                sda_d = scl_oe_q ? ~bit_val : sda_oe_q; // after scl low
                scl_d = ~step_q[0];
                nh    = step_q[0];
                if (brg_done) begin
                    if (step_q == 2'd0) begin
                        step_d = 2'd1;
                    end else begin
                        smp    = 1'b1;
                        step_d = 2'd0;
                        if (bit_q == last) begin
                            st_d  = S_IDLE;
                            scl_d = 1'b1;
                        end else begin
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
        if (!master_en) begin
            st_d  = S_IDLE;
            sda_d = 1'b0;
            scl_d = 1'b0;
        end
    end

    // event sources gathered per status bit
    wire byte_ev = smp & (kind_q != K_ACK) & (bit_q == `I2M_RX_LAST);
    wire ack_ev  = smp & ((kind_q == K_ACK) |
                   ((kind_q == K_TX) & (bit_q == `I2M_TX_LAST)));
    assign ev = {gen_rs, ack_ev, byte_ev,
                 stop_det | gen_p, start_det | gen_s};

    // bits clear only when software reads them; a new event wins
    wire [`I2M_NEV-1:0] rd_clr = (rd & hit_ist) ?
                                 prdata_q[`I2M_NEV-1:0] : '0;
    assign irqs_d = (irqs_q & ~rd_clr) | ev;

    // read data mux
    always_comb begin
        rd_data = '0;
        case (1'b1)
            hit_ctrl: begin
                rd_data[`I2M_CTRL_MODE_HI:`I2M_CTRL_MODE_LO] = mode_q;
                rd_data[`I2M_CTRL_EN]   = en_q;
                rd_data[`I2M_CTRL_WRITE_COLLISION_FLAG] = write_collision_flag_q;
            end
            hit_cmd: begin
                rd_data[`I2M_CMD_START]  = start_req_q;
                rd_data[`I2M_CMD_RSTART] = rstart_req_q;
                rd_data[`I2M_CMD_STOP]   = stop_req_q;
                rd_data[`I2M_CMD_RCV]    = rcv_q;
                rd_data[`I2M_CMD_ACKSEQ] = ackseq_q;
                rd_data[`I2M_CMD_ACKDT]  = ackdt_q;
                rd_data[`I2M_CMD_FWSDA]  = fw_sda_q;
                rd_data[`I2M_CMD_FWSCL]  = fw_scl_q;
            end
            hit_stat: begin
                rd_data[`I2M_STAT_SSEEN] = sseen_q;
                rd_data[`I2M_STAT_PSEEN] = pseen_q;
                rd_data[`I2M_STAT_ACKST] = ackst_q;
                rd_data[`I2M_STAT_BUSY]  = busy;
                rd_data[`I2M_STAT_SCL]   = scl_s;
                rd_data[`I2M_STAT_SDA]   = sda_s;
                rd_data[`I2M_STAT_EVT]   = |irqs_q;
            end
            hit_buf:  rd_data[7:0] = sh_q;
            hit_rate: rd_data[7:0] = rate_q;
            hit_ist:  rd_data[`I2M_NEV-1:0] = irqs_q;
            hit_imsk: rd_data[`I2M_NEV-1:0] = mask_q;
            default:  rd_data = '0;
        endcase
    end

    // apb answer: data, ready and error flopped in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= setup ? rd_data : prdata_q;
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 4'h0;
            en_q   <= 1'b0;
            rate_q <= `I2M_RATE_RST;
            mask_q <= '0;
        end else begin
            if (wr_ctrl) begin
                mode_q <= pwdata[`I2M_CTRL_MODE_HI:`I2M_CTRL_MODE_LO];
                en_q   <= pwdata[`I2M_CTRL_EN];
            end
            if (wr & hit_rate) rate_q <= pwdata[7:0];
            if (wr & hit_imsk) mask_q <= pwdata[`I2M_NEV-1:0];
        end
    end

    // collision flag, write one clears, a new collision wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag_q <= 1'b0;
        end else if (write_collision_flag_set) begin
            write_collision_flag_q <= 1'b1;
        end else if (wr_ctrl & pwdata[`I2M_CTRL_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_q <= 1'b0;
        end
    end

    // requests taken only while idle; start, repeated start and stop cleared by hardware at their end, receive and acknowledge at launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_req_q  <= 1'b0;
            rstart_req_q <= 1'b0;
            stop_req_q   <= 1'b0;
            rcv_q        <= 1'b0;
            ackseq_q     <= 1'b0;
        end else if (!master_en) begin
            start_req_q  <= 1'b0;
            rstart_req_q <= 1'b0;
            stop_req_q   <= 1'b0;
            rcv_q        <= 1'b0;
            ackseq_q     <= 1'b0;
        end else if (cmd_ok) begin
            start_req_q  <= pwdata[`I2M_CMD_START];
            rstart_req_q <= pwdata[`I2M_CMD_RSTART];
            stop_req_q   <= pwdata[`I2M_CMD_STOP];
            rcv_q        <= pwdata[`I2M_CMD_RCV];
            ackseq_q     <= pwdata[`I2M_CMD_ACKSEQ];
        end else begin
            if (gen_s) start_req_q <= 1'b0;
            if (gen_rs) rstart_req_q <= 1'b0;
            if (gen_p) stop_req_q <= 1'b0;
            if (launch & (kind_d == K_RX)) rcv_q <= 1'b0;
            if (launch & (kind_d == K_ACK)) ackseq_q <= 1'b0;
        end
    end

    // acknowledge value and firmware pin controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ackdt_q  <= 1'b0;
            fw_sda_q <= 1'b0;
            fw_scl_q <= 1'b0;
        end else begin
            if (cmd_ok) ackdt_q <= pwdata[`I2M_CMD_ACKDT];
            if (wr_cmd) begin
                fw_sda_q <= pwdata[`I2M_CMD_FWSDA];
                fw_scl_q <= pwdata[`I2M_CMD_FWSCL];
            end
        end
    end

    // address byte with direction bit goes out as written
    // sampled bits shift in from the right
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q    <= 8'h00;
            ackst_q <= 1'b0;
        end else if (tx_go) begin
            sh_q <= pwdata[7:0];
        end else if (smp & (kind_q != K_ACK)) begin
            if (bit_q < `I2M_TX_LAST) sh_q <= {sh_q[6:0], sda_s};
            else ackst_q <= sda_s;
        end
    end

    // sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= S_IDLE;
            step_q <= 2'd0;
            bit_q  <= 4'h0;
            kind_q <= K_TX;
        end else begin
            st_q   <= st_d;
            step_q <= step_d;
            bit_q  <= bit_d;
            kind_q <= kind_d;
        end
    end

    // pull-low enables, firmware mode hands pins to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            lo_q     <= 1'b0;
        end else begin
            sda_oe_q <= fw_en ? fw_sda_q : sda_d;
            scl_oe_q <= fw_en ? fw_scl_q : scl_d;
            lo_q     <= 1'b0;
        end
    end

    // bus condition flags, cleared while the port is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sseen_q    <= 1'b0;
            pseen_q    <= 1'b0;
            sda_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= sda_s;
            if (!en_q) begin
                sseen_q <= 1'b0;
                pseen_q <= 1'b0;
            end else if (start_det) begin
                sseen_q <= 1'b1;
                pseen_q <= 1'b0;
            end else if (stop_det) begin
                sseen_q <= 1'b0;
                pseen_q <= 1'b1;
            end
        end
    end

    // sticky events and the masked interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqs_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            irqs_q <= irqs_d;
            irq_q  <= |(irqs_d & mask_q);
        end
    end

    // outputs straight from flops
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign scl_oe  = scl_oe_q;
    assign sda_oe  = sda_oe_q;
    assign scl_out = lo_q;
    assign sda_out = lo_q;
    assign irq     = irq_q;

endmodule

// File: rtl/i2m_sync.sv
// two-stage synchroniser for pin inputs
// assumes idle-high open-drain lines, so stages reset to one
`timescale 1ns/1ps
module i2m_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// File: shared/i2m_map.svh
// register offsets, field positions and reset values of the i2c master
// assumes an 8-bit apb byte address with one aligned word per register
`ifndef I2M_MAP_SVH
`define I2M_MAP_SVH

// register byte offsets
`define I2M_CTRL_OFF  8'h00
`define I2M_CMD_OFF   8'h04
`define I2M_STAT_OFF  8'h08
`define I2M_BUF_OFF   8'h0c
`define I2M_RATE_OFF  8'h10
`define I2M_IST_OFF   8'h14
`define I2M_IMSK_OFF  8'h18

// port_control_one fields
`define I2M_CTRL_MODE_LO 0
`define I2M_CTRL_MODE_HI 3
`define I2M_CTRL_EN      4
`define I2M_CTRL_WRITE_COLLISION_FLAG    7

// mode_select_field encodings
`define I2M_MODE_MST 4'h8
`define I2M_MODE_FW  4'hb

// command register fields
`define I2M_CMD_START  0
`define I2M_CMD_RSTART 1
`define I2M_CMD_STOP   2
`define I2M_CMD_RCV    3
`define I2M_CMD_ACKSEQ 4
`define I2M_CMD_ACKDT  5
`define I2M_CMD_FWSDA  8
`define I2M_CMD_FWSCL  9

// status register fields
`define I2M_STAT_SSEEN 0
`define I2M_STAT_PSEEN 1
`define I2M_STAT_ACKST 2
`define I2M_STAT_BUSY  3
`define I2M_STAT_SCL   4
`define I2M_STAT_SDA   5
`define I2M_STAT_EVT   6

// event bits of interrupt status and mask
`define I2M_EV_S    0
`define I2M_EV_P    1
`define I2M_EV_BYTE 2
`define I2M_EV_ACK  3
`define I2M_EV_RS   4
`define I2M_NEV     5

// reset values and last bit indices
`define I2M_RATE_RST 8'h13
`define I2M_TX_LAST  4'h8
`define I2M_RX_LAST  4'h7

`endif

// File: shared/i2m_pkg.sv
// types shared by the i2c master engine files
// assumes nothing beyond the compile order
package i2m_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_RSTART,
        S_STOP,
        S_BIT
    } i2m_state_e;

    // kind of bit sequence being clocked
    typedef enum logic [1:0] {
        K_TX,
        K_RX,
        K_ACK
    } i2m_kind_e;

endpackage

// File: testbench/i2m_engine_checker.sv
// port assertions for the i2c master engine
// assumes rate is written over apb before any bus traffic
`timescale 1ns/1ps
module i2m_engine_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0]  rate_q;
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    // mirror rate, count scl low and high phase lengths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= 8'h13;
            lo_q   <= '0;
            hi_q   <= '0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 8'h10)
                rate_q <= pwdata[7:0];
            lo_q <= scl_oe ? lo_q + 16'd1 : '0;
            hi_q <= scl_oe ? '0 : hi_q + 16'(scl_in && !(&hi_q));
        end
    end
    ready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    bad_addr_a: assert property (psel && !penable && paddr > 8'h18
        |=> pslverr) else $error("unmapped access not refused");
    pins_low_a: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    scl_low_a: assert property ($fell(scl_oe) |-> lo_q > 16'(rate_q))
        else $error("scl low phase too short");
    scl_high_a: assert property ($rose(scl_oe) |-> hi_q > 16'(rate_q) + 1)
        else $error("scl high phase too short");
    stretch_hold_a: assert property (!scl_oe && !scl_in |=> !scl_oe)
        else $error("scl pulled during stretch");
    start_gap_a: assert property ($rose(sda_oe) && !scl_oe |-> !scl_oe[*2])
        else $error("start without scl high time");
    stop_idle_a: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe[*2])
        else $error("bus taken right after stop");
endmodule

bind i2m_engine i2m_engine_checker chk_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe
);

// File: testbench/i2m_slave_model.sv
// two-wire bus slave: acks, answers reads, may stretch scl
// assumes open-drain lines with pull-ups made by the bench
`timescale 1ns/1ps
module i2m_slave_model (
    input  wire logic       pclk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       stretch,
    input  wire logic [7:0] tx_byte,
    output logic            scl_pull,
    output logic            sda_pull,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh;
    int         n = 99;
    logic       rd = 1'b0;
    logic       adr = 1'b0;
    initial scl_pull = 1'b0;
    initial sda_pull = 1'b0;
    // start and stop seen while scl is high
    always @(negedge sda) begin
        if (scl) begin
            n = 0;
            adr = 1'b1;
        end
    end
    always @(posedge sda) begin
        if (scl) n = 99;
    end
    // shift in on rising scl, ninth bit is the acknowledge
    always @(posedge scl) begin
        if (n < 9) begin
            sh = {sh[6:0], sda};
            n = n + 1;
        end
    end
    // change sda only while scl is low, then maybe hold scl
    always @(negedge scl) begin
        if (n == 8) begin
            if (adr) rd = sh[0];
            if (!adr && !rd) rx_byte = sh;
            sda_pull = adr || !rd;
        end else if (n == 9) begin
            rd = rd && (adr || !sh[0]);
            adr = 1'b0;
            n = 0;
            sda_pull = rd && !tx_byte[7];
        end else if (n > 0 && n < 8) begin
            sda_pull = rd && !adr && !tx_byte[7-n];
        end
        if (stretch) begin
            scl_pull = 1'b1;
            repeat (6) @(posedge pclk);
            scl_pull <= 1'b0;
        end
    end
endmodule

// File: testbench/test_i2m_engine.sv
// bench for the i2c master engine with one slave model
// assumes the checker is bound to the engine
`timescale 1ns/1ps
module test_i2m_engine;
    logic        pclk, presetn, psel, penable, pwrite, e, stretch;
    logic [7:0]  paddr, rx_byte;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
    logic        scl_pull, sda_pull;
    int          n_mismatch = 0;
    int          checks = 0;
    wire         scl = !(scl_oe || scl_pull);
    wire         sda = !(sda_oe || sda_pull);
    i2m_engine dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out,
        .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .irq);
    i2m_slave_model sl_u (.pclk, .scl, .sda, .stretch, .tx_byte(8'hc3),
        .scl_pull, .sda_pull, .rx_byte);
    always #4 pclk = ~pclk;
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, g, x);
        end
    endtask
    // one apb transfer, result in r and e
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll until the sequencer is idle
    task automatic wt;
        do apb(0, 8'h08, 0); while (r[3] === 1'b1);
    endtask
    task automatic t_regs;
        apb(0, 8'h10, 0);
        chk(r, 32'h13);
        apb(0, 8'h1c, 0);
        chk({r[30:0], e}, 32'h1);
        apb(1, 8'h10, 32'h2);
        apb(1, 8'h18, 32'h1f);
        apb(1, 8'h00, 32'h18);
    endtask
    task automatic t_master;
        // bus idle, begin with a start
        apb(1, 8'h04, 32'h1);
        apb(1, 8'h0c, 32'h55);
        apb(0, 8'h00, 0);
        chk(r, 32'h98);
        wt();
        chk(32'(irq), 32'h1);
        apb(0, 8'h04, 0);
        chk(r, 0);
        apb(0, 8'h14, 0);
        chk(r, 32'h1);
        apb(1, 8'h00, 32'h98);
        chk(32'(irq), 0);
        apb(1, 8'h0c, 32'h54);
        wt();
        chk(r & 32'h44, 32'h40);
        stretch <= 1'b1;
        apb(1, 8'h0c, 32'ha5);
        wt();
        stretch <= 1'b0;
        chk(32'(rx_byte), 32'ha5);
        apb(1, 8'h04, 32'h2);
        wt();
        apb(1, 8'h0c, 32'h55);
        wt();
        apb(1, 8'h04, 32'h8);
        wt();
        apb(0, 8'h0c, 0);
        chk(r, 32'hc3);
        apb(1, 8'h04, 32'h30);
        wt();
        apb(0, 8'h14, 0);
        chk(r & 32'h1c, 32'h1c);
        apb(1, 8'h04, 32'h4);
        wt();
        apb(0, 8'h14, 0);
        chk(r & 32'h2, 32'h2);
    endtask
    task automatic t_fw;
        apb(1, 8'h00, 32'h1b);
        apb(1, 8'h04, 32'h100);
        apb(1, 8'h18, 0);
        apb(0, 8'h08, 0);
        chk(r & 32'h1, 32'h1);
        apb(1, 8'h04, 0);
        apb(0, 8'h14, 0);
        apb(0, 8'h08, 0);
        chk(r & 32'h42, 32'h42);
        chk(32'(irq), 0);
        apb(0, 8'h14, 0);
        chk(r, 32'h2);
        apb(1, 8'h00, 0);
        apb(0, 8'h08, 0);
        chk(r & 32'h3, 0);
        apb(1, 8'h04, 32'h1);
        apb(0, 8'h04, 0);
        chk({r[29:0], sda_oe, scl_oe}, 0);
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #320000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata, stretch} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_master();
        t_fw();
        stop_test();
    end
endmodule
